// >>> inc/fpu_bus_pkg.sv
// Purpose: Shared constants and types of the coprocessor host bus interface.
// Assumes: The core clock is the double-rate bus clock.
// Notes:   Categories ride in the command word.
`default_nettype none
package fpu_bus_pkg;
    // ----------------------------------------------------------------
    // Widths and timing
    // ----------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CLASS_LSB = 16;
    localparam int CLASS_W = 4;
    localparam int COUNT_W = 5;

    // ----------------------------------------------------------------
    // Instruction categories, carried in the command word
    // ----------------------------------------------------------------
    typedef enum logic [CLASS_W-1:0] {
        CLS_A_REG     = 4'h0,  // Register-only, no operands.
        CLS_B_LD32    = 4'h1,  // Load, one word, early write allowed.
        CLS_B_LD64    = 4'h2,  // Load, two words, early write allowed.
        CLS_B_MATH32  = 4'h3,  // Arithmetic with one memory word.
        CLS_B_MATH64  = 4'h4,  // Arithmetic with two memory words.
        CLS_C_LD16    = 4'h5,  // Load paced by operand request, one word.
        CLS_C_LD80    = 4'h6,  // Load paced by operand request, three words.
        CLS_C_LDENV   = 4'h7,  // Environment block load.
        CLS_C_RESTORE = 4'h8,  // Full state restore.
        CLS_C_ST32    = 4'h9,  // Store of a 16-bit or 32-bit value.
        CLS_C_ST64    = 4'ha,  // Store of a 64-bit value.
        CLS_C_ST80    = 4'hb,  // Store of an 80-bit value.
        CLS_C_SAVE    = 4'hc,  // Full state save.
        CLS_D_STCTL   = 4'hd,  // Store of status or control word.
        CLS_E_CTRL    = 4'he   // Control, accepted regardless of busy.
    } class_type;

    // Host cycle states of the interface, Gray coded except the direct ST_DONE to ST_IDLE step.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b11,
        ST_END  = 2'b10
    } cycle_state_type;

    // Operand words that follow the opcode, per category.
    function automatic logic [COUNT_W-1:0] operand_count(input class_type c);
        case (c)
            CLS_B_LD32, CLS_B_MATH32, CLS_C_LD16, CLS_C_ST32, CLS_D_STCTL: return 5'h01;
            CLS_B_LD64, CLS_B_MATH64, CLS_C_ST64: return 5'h02;
            CLS_C_LD80, CLS_C_ST80: return 5'h03;
            CLS_C_LDENV: return 5'h07;
            CLS_C_RESTORE, CLS_C_SAVE: return 5'h1b;
            default: return 5'h00;
        endcase
    endfunction

    // True for categories whose operands are read by the host.
    function automatic logic class_reads(input class_type c);
        return (c == CLS_C_ST32) || (c == CLS_C_ST64) || (c == CLS_C_ST80) ||
               (c == CLS_C_SAVE) || (c == CLS_D_STCTL);
    endfunction

    // True for categories synchronised by busy alone.
    function automatic logic class_b(input class_type c);
        return (c == CLS_B_LD32) || (c == CLS_B_LD64) ||
               (c == CLS_B_MATH32) || (c == CLS_B_MATH64);
    endfunction

    // Registered state of the interface.
    typedef struct packed {
        cycle_state_type fsm;
        logic pendValid;
        logic pendCmd;
        logic pendWrite;
        logic accCmd;
        logic accWrite;
        logic cmdFull;
        logic [DATA_W-1:0] cmdBuf;
        class_type cls;
        logic [COUNT_W-1:0] remaining;
        logic [COUNT_W-1:0] idx;
        logic engBusyPrev;
        logic phase;
        logic sig;
        logic [DATA_W-1:0] dataOut;
        logic dataOeN;
        logic readyN;
        logic busyN;
        logic opReq;
        logic errorN;
        logic oeN;
        logic [DATA_W-1:0] opcodeWord;
        logic opcodeStart;
        logic [DATA_W-1:0] operandWord;
        logic [COUNT_W-1:0] operandIndex;
        logic operandStart;
        logic storeAck;
    } iface_state_type;

    // Signature state: idle, error active, outputs released.
    localparam iface_state_type IFACE_RESET = '{
        fsm: ST_IDLE, cls: CLS_A_REG, readyN: 1'b1, busyN: 1'b1,
        errorN: 1'b0, oeN: 1'b1, dataOeN: 1'b1, sig: 1'b1, default: '0};
endpackage
`default_nettype wire

// >>> hdl/bus_cycle_tracker.sv
// Purpose: Follows host bus cycles from strobe and system ready.
// Assumes: Inputs are synchronous to the double-rate clock.
// Notes:   Up to two open cycles for pipelined hosts.
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_tracker (
    // Clock and resets
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hardResetIn,
    // Bus observation
    input wire logic enable,
    input wire logic addrStrobeN,
    input wire logic readyInN,
    // Tracking result
    output logic cycleEnd
);
    logic [1:0] openReg;
    logic [1:0] openNext;

    // -----------------------------------------------------------------
    // Open cycle count
    // -----------------------------------------------------------------

    // A strobe opens a cycle, a sampled ready closes one.
    always_comb begin
        cycleEnd = enable && !readyInN && (openReg != 2'h0); // RULE12
        openNext = openReg;
        if (enable && !addrStrobeN && !cycleEnd && openReg != 2'h2) begin
            openNext = openReg + 2'h1; // RULE19
        end else if (cycleEnd && (addrStrobeN || !enable)) begin
            openNext = openReg - 2'h1;
        end
        if (hardResetIn) begin
            openNext = 2'h0;
        end
    end

    // Registers the count.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            openReg <= 2'h0;
        end else begin
            openReg <= openNext;
        end
    end
endmodule // bus_cycle_tracker
`default_nettype wire

// >>> hdl/fpu_host_iface.sv
// Purpose: Host bus interface of a floating-point coprocessor.
// Assumes: core_clk is the host's double-rate clock.
// Notes:   Category rides in the command word.
//
// Contract
// [RULE1] Internal rate is the double-rate clock divided by two.
// [RULE2] Inputs sampled and outputs launched on the double-rate rising edge.
// [RULE3] Selects, direction and port select are taken with the strobe.
// [RULE4] A cycle is ours only with both selects and the strobe together.
// [RULE5] Low port select means command port, high means data port.
// [RULE6] Direction sampled with the strobe decides write or read.
// [RULE7] Data travel on 32 two-way lines, bit 31 most significant.
// [RULE8] Busy is asserted while the engine is occupied.
// [RULE9] After the signature period error follows the summary bit.
// [RULE10] Error is asserted before busy drops for the same instruction.
// [RULE11] Request only while transfers remain and busy is asserted.
// [RULE12] System ready and strobe track every bus cycle.
// [RULE13] Own ready is independent of busy and request.
// [RULE14] After hard reset: ready, busy, request inactive, error active.
// [RULE15] Host releases hard reset synchronously, then waits.
// [RULE16] Chip enable low floats outputs and ignores inputs.
// [RULE17] Coprocessor mode asserts ready right after each strobe.
// [RULE18] Mapped mode withholds ready on cycles it cannot complete.
// [RULE19] Pipelined and plain cycles are both followed.
// [RULE20] Opcode plus operand cycles per category: 2, 3, 4, 8 or 28; register-only and control categories take 1.
// [RULE21] Control, initialise and 32/64-bit load opcodes are accepted while busy.
// [RULE22] Register-only instructions hold busy during execution.
// [RULE23] Stores hold busy, request low while rounding; mapped reads wait.
// [RULE24] Status or control stores complete without busy.
// [RULE25] Control instructions assert busy and keep request inactive.
// [RULE26] Operand cycles are counted and routed per word.
`timescale 1ns/1ps
`default_nettype none
module fpu_host_iface
    import fpu_bus_pkg::*;
(
    // Clock and resets
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hardResetIn,
    // Host bus control
    input wire logic chipEnableIn,
    input wire logic addrStrobeN,
    input wire logic selectLowN,
    input wire logic selectHigh,
    input wire logic portSelectN,
    input wire logic writeNotRead,
    input wire logic readyInN,
    input wire logic mappedMode,
    // Host data lines
    input wire logic [DATA_W-1:0] dataLinesIn,
    output logic [DATA_W-1:0] dataLinesOut,
    output logic dataLinesOeN,
    // Host status lines and their enables
    output logic cycleDoneOutN,
    output logic busyN,
    output logic operandRequest,
    output logic errorN,
    output logic statusOeN,
    // Engine side
    input wire logic engineBusy,
    input wire logic errorSummaryBit,
    input wire logic storeReady,
    input wire logic [DATA_W-1:0] storeWord,
    output logic [DATA_W-1:0] opcodeWord,
    output logic opcodeStart,
    output logic [DATA_W-1:0] operandWord,
    output logic [COUNT_W-1:0] operandIndex,
    output logic operandStart,
    output logic storeAck
);
    iface_state_type sReg;
    iface_state_type sNext;
    logic cycleEnd;
    logic hit;
    logic curCmd;
    logic curWrite;
    logic canDone;
    logic busyAct;
    class_type bufCls;

    // -----------------------------------------------------------------
    // Bus cycle tracking
    // -----------------------------------------------------------------

    // Follows every host cycle so pipelined strobes stay aligned.
    bus_cycle_tracker tracker (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .hardResetIn(hardResetIn),
        .enable(chipEnableIn),
        .addrStrobeN(addrStrobeN),
        .readyInN(readyInN),
        .cycleEnd(cycleEnd)
    );

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------

    // Decodes cycles, moves words, derives status.
    always_comb begin
        sNext = sReg;
        bufCls = class_type'(sReg.cmdBuf[CLASS_LSB +: CLASS_W]);
        // Ours only while enabled with both selects.
        hit = chipEnableIn && !addrStrobeN && !selectLowN && selectHigh; // RULE4 RULE16
        curCmd = sReg.accCmd;
        curWrite = sReg.accWrite;
        sNext.phase = !sReg.phase; // RULE1
        sNext.engBusyPrev = engineBusy;
        sNext.opcodeStart = 1'b0;
        sNext.operandStart = 1'b0;
        sNext.storeAck = 1'b0;
        sNext.readyN = 1'b1;
        sNext.oeN = !chipEnableIn; // RULE16

        // Hands a buffered opcode to the engine on the internal rate.
        if (sReg.cmdFull && sReg.remaining == 5'h00 && sReg.phase &&
            (!engineBusy || bufCls == CLS_E_CTRL)) begin // RULE21
            sNext.opcodeStart = 1'b1;
            sNext.opcodeWord = sReg.cmdBuf;
            sNext.cls = bufCls;
            sNext.remaining = operand_count(bufCls); // RULE20 RULE26
            sNext.idx = 5'h00;
            sNext.cmdFull = 1'b0;
        end

        // Can the held cycle finish now.
        if (!mappedMode) begin
            canDone = 1'b1; // RULE17
        end else if (curCmd && curWrite) begin
            canDone = !sReg.cmdFull; // RULE18 RULE21
        end else if (curWrite) begin
            canDone = sReg.remaining != 5'h00 && !class_reads(sReg.cls) &&
                      !(class_b(sReg.cls) && engineBusy); // RULE18
        end else begin
            canDone = storeReady && sReg.remaining != 5'h00 && class_reads(sReg.cls); // RULE23
        end

        // A strobe during a held cycle waits.
        if (hit && sReg.fsm != ST_IDLE) begin
            sNext.pendValid = 1'b1; // RULE19
            sNext.pendCmd = !portSelectN;
            sNext.pendWrite = writeNotRead;
        end

        case (sReg.fsm)
            ST_IDLE: begin
                if (hit) begin
                    sNext.accCmd = !portSelectN; // RULE3 RULE5
                    sNext.accWrite = writeNotRead; // RULE6
                    sNext.fsm = ST_WAIT;
                end else if (sReg.pendValid) begin
                    sNext.accCmd = sReg.pendCmd;
                    sNext.accWrite = sReg.pendWrite;
                    sNext.pendValid = 1'b0;
                    sNext.fsm = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (canDone) begin
                    sNext.readyN = 1'b0; // RULE13
                    sNext.fsm = ST_DONE;
                    if (curCmd && curWrite) begin
                        sNext.cmdBuf = dataLinesIn; // RULE7
                        sNext.cmdFull = 1'b1;
                        sNext.sig = 1'b0;
                    end else if (curWrite) begin
                        if (sReg.remaining != 5'h00) begin
                            sNext.operandWord = dataLinesIn; // RULE26
                            sNext.operandIndex = sReg.idx;
                            sNext.operandStart = 1'b1;
                            sNext.idx = sReg.idx + 5'h01;
                            sNext.remaining = sReg.remaining - 5'h01;
                        end
                    end else begin
                        sNext.dataOut = storeWord; // RULE7
                        sNext.dataOeN = !chipEnableIn;
                        sNext.storeAck = 1'b1;
                        if (sReg.remaining != 5'h00) begin
                            sNext.idx = sReg.idx + 5'h01;
                            sNext.remaining = sReg.remaining - 5'h01;
                        end
                    end
                end
            end
            ST_DONE: begin
                if (cycleEnd) begin
                    sNext.fsm = ST_IDLE; // RULE12
                    sNext.dataOeN = 1'b1;
                end else begin
                    sNext.fsm = ST_END;
                end
            end
            ST_END: begin
                if (cycleEnd) begin
                    sNext.fsm = ST_IDLE;
                    sNext.dataOeN = 1'b1;
                end
            end
            default: begin
                sNext.fsm = ST_IDLE;
            end
        endcase

        // Busy holds one extra cycle so error settles first.
        busyAct = engineBusy || sReg.engBusyPrev || // RULE8 RULE10 RULE22
                  (sReg.opcodeStart && sReg.cls != CLS_D_STCTL) ||
                  (sReg.cmdFull && bufCls != CLS_D_STCTL) || // RULE24 RULE25
                  (sReg.remaining != 5'h00 && !class_b(sReg.cls) &&
                   sReg.cls != CLS_D_STCTL); // RULE23
        sNext.busyN = !busyAct;
        sNext.opReq = busyAct && sReg.remaining != 5'h00 && !class_b(sReg.cls) &&
                      sReg.cls != CLS_D_STCTL && sReg.cls != CLS_E_CTRL &&
                      (!class_reads(sReg.cls) || storeReady); // RULE11 RULE23 RULE25
        sNext.errorN = sReg.sig ? 1'b0 : !errorSummaryBit; // RULE9 RULE10
        if (!chipEnableIn) begin
            sNext.dataOeN = 1'b1; // RULE16
        end

        // Hard reset restores the signature state.
        if (hardResetIn) begin
            sNext = IFACE_RESET; // RULE14 RULE15
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------

    // Registers all state on the double-rate rising edge.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sReg <= IFACE_RESET;
        end else begin
            sReg <= sNext; // RULE2
        end
    end

    // -----------------------------------------------------------------
    // Outputs, each straight from a register field
    // -----------------------------------------------------------------

    // Drives the host and engine ports.
    assign dataLinesOut = sReg.dataOut;
    assign dataLinesOeN = sReg.dataOeN;
    assign cycleDoneOutN = sReg.readyN;
    assign busyN = sReg.busyN;
    assign operandRequest = sReg.opReq;
    assign errorN = sReg.errorN;
    assign statusOeN = sReg.oeN;
    assign opcodeWord = sReg.opcodeWord;
    assign opcodeStart = sReg.opcodeStart;
    assign operandWord = sReg.operandWord;
    assign operandIndex = sReg.operandIndex;
    assign operandStart = sReg.operandStart;
    assign storeAck = sReg.storeAck;
endmodule // fpu_host_iface
`default_nettype wire

// >>> verif/fpu_host_iface_properties.sv
// Purpose: Port checks of the host bus interface.
// Assumes: One clock; rst_b resets.
// Notes:   Bound to every instance.
`timescale 1ns/1ps
`default_nettype none
module fpu_host_iface_properties
    import fpu_bus_pkg::*;
(
    // Clock, resets, control
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hardResetIn,
    input wire logic chipEnableIn,
    input wire logic addrStrobeN,
    input wire logic selectLowN,
    input wire logic selectHigh,
    input wire logic mappedMode,
    // Status outputs
    input wire logic cycleDoneOutN,
    input wire logic busyN,
    input wire logic operandRequest,
    input wire logic errorN,
    input wire logic statusOeN,
    // Engine side
    input wire logic engineBusy,
    input wire logic errorSummaryBit,
    input wire logic opcodeStart,
    input wire logic operandStart
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // A cycle addressed to this device.
    wire logic ours = chipEnableIn && !addrStrobeN && !selectLowN && selectHigh;
    property p_sig; hardResetIn |=> busyN && cycleDoneOutN && !operandRequest && !errorN; endproperty
    a_sig: assert property (p_sig) else $error("signature state missing");
    property p_req; operandRequest |-> !busyN; endproperty
    a_req: assert property (p_req) else $error("request while idle");
    property p_oe; !hardResetIn ##1 !hardResetIn |-> statusOeN == !$past(chipEnableIn); endproperty
    a_oe: assert property (p_oe) else $error("status enable wrong");
    property p_cop; ours && !mappedMode && !hardResetIn |-> ##[2:3] !cycleDoneOutN; endproperty
    a_cop: assert property (p_cop) else $error("ready late");
    property p_pulse; $fell(cycleDoneOutN) |=> cycleDoneOutN; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_cause; $fell(cycleDoneOutN) && !mappedMode |-> $past(ours, 2) || $past(ours, 3); endproperty
    a_cause: assert property (p_cause) else $error("ready without strobe");
    property p_busy; (engineBusy && chipEnableIn && !hardResetIn) [*3] |-> !busyN; endproperty
    a_busy: assert property (p_busy) else $error("busy missing");
    property p_err; errorSummaryBit [*3] |-> !errorN; endproperty
    a_err: assert property (p_err) else $error("error does not follow summary");
    property p_errfirst; $rose(busyN) && errorSummaryBit && $past(errorSummaryBit, 3) |-> !errorN;
    endproperty
    a_errfirst: assert property (p_errfirst) else $error("busy before error");
    c_cop: cover property (ours && !mappedMode);
    c_map: cover property ($fell(cycleDoneOutN) && mappedMode);
    c_opnd: cover property (operandStart);
    c_opc: cover property (opcodeStart && !errorN);
endmodule // fpu_host_iface_properties
bind fpu_host_iface fpu_host_iface_properties fpu_host_iface_properties_inst (.core_clk, .rst_b,
    .hardResetIn, .chipEnableIn, .addrStrobeN, .selectLowN, .selectHigh, .mappedMode,
    .cycleDoneOutN, .busyN, .operandRequest, .errorN, .statusOeN, .engineBusy,
    .errorSummaryBit, .opcodeStart, .operandStart);
`default_nettype wire

// >>> verif/host_bus_model.sv
// Purpose: Host side of the coprocessor bus.
// Assumes: Tasks start just after a rising edge.
// Notes:   Released lines carry the inverse value.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
    import fpu_bus_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Lines toward the device
    output logic addrStrobeN = 1'b1,
    output logic portSelectN = 1'b1,
    output logic writeNotRead = 1'b0,
    output logic readyInN = 1'b1,
    output logic [DATA_W-1:0] dataLinesIn,
    // Lines from the device
    input wire logic cycleDoneOutN,
    input wire logic [DATA_W-1:0] dataLinesOut,
    input wire logic dataLinesOeN
);
    int lag = 0;
    logic [DATA_W-1:0] hostData = '0;
    // Device value while it drives, else the host's.
    assign dataLinesIn = dataLinesOeN ? hostData : dataLinesOut;
    // One non-pipelined cycle, qualifiers held until ready.
    task automatic xfer(input logic cmd, input logic wr, input logic [DATA_W-1:0] w,
                        input int limit, output logic [DATA_W-1:0] r, output int n);
        n = 0;
        r = '0;
        addrStrobeN <= 1'b0;
        portSelectN <= !cmd;
        writeNotRead <= wr;
        hostData <= w;
        @(posedge core_clk);
        addrStrobeN <= 1'b1;
        while (cycleDoneOutN !== 1'b0 && n < limit) begin
            @(posedge core_clk);
            n++;
        end
        if (cycleDoneOutN === 1'b0) begin
            r = dataLinesIn;
            repeat (lag) @(posedge core_clk);
            readyInN <= 1'b0;
            @(posedge core_clk);
        end
        readyInN <= 1'b1;
        portSelectN <= cmd;
        writeNotRead <= !wr;
        hostData <= ~w;
        @(posedge core_clk);
    endtask
endmodule // host_bus_model
`default_nettype wire

// >>> verif/coprocessor_host_bus_interface_tb.sv
// Purpose: Self-checking bench of the host bus interface.
// Assumes: The bench plays the engine.
// Notes:   Random words from a fixed-seed shift register.
`timescale 1ns/1ps
`default_nettype none
module coprocessor_host_bus_interface_tb
    import fpu_bus_pkg::*;
;
    logic core_clk = 1'b0, rst_b = 1'b0, hardResetIn = 1'b0, chipEnableIn = 1'b1;
    logic selectLowN = 1'b0, selectHigh = 1'b1, mappedMode = 1'b0;
    logic errorSummaryBit = 1'b0, storeReady = 1'b1;
    logic [DATA_W-1:0] storeWord = '0, seed = 32'h00013398, opQ[$], wordQ[$];
    logic [COUNT_W-1:0] idxQ[$];
    logic addrStrobeN, portSelectN, writeNotRead, readyInN, dataLinesOeN, cycleDoneOutN;
    logic busyN, operandRequest, errorN, statusOeN, opcodeStart, operandStart, storeAck;
    logic reqSeen, busySeen;
    logic [DATA_W-1:0] dataLinesIn, dataLinesOut, opcodeWord, operandWord;
    logic [COUNT_W-1:0] operandIndex;
    wire logic engineBusy;
    int fail_count = 0, cmp_count = 0, engCnt = 0, ackCnt = 0, lastN = 0;
    // The clock inverts every half period.
    always #2.5 core_clk = ~core_clk;
    fpu_host_iface fpu_host_iface_inst (.core_clk, .rst_b, .hardResetIn, .chipEnableIn,
        .addrStrobeN, .selectLowN, .selectHigh, .portSelectN, .writeNotRead, .readyInN,
        .mappedMode, .dataLinesIn, .dataLinesOut, .dataLinesOeN, .cycleDoneOutN, .busyN,
        .operandRequest, .errorN, .statusOeN, .engineBusy, .errorSummaryBit, .storeReady,
        .storeWord, .opcodeWord, .opcodeStart, .operandWord, .operandIndex, .operandStart,
        .storeAck);
    host_bus_model host_bus_model_inst (.core_clk, .addrStrobeN, .portSelectN,
        .writeNotRead, .readyInN, .dataLinesIn, .cycleDoneOutN, .dataLinesOut, .dataLinesOeN);
    // Engine stand-in: busy after each handed word, except status stores.
    always @(posedge core_clk) begin
        if ((opcodeStart | operandStart | storeAck) === 1'b1 && opcodeWord[19:16] !== 4'hd)
            engCnt <= 6;
        else if (engCnt > 0)
            engCnt <= engCnt - 1;
    end
    assign engineBusy = engCnt > 0;
    // Records engine-side traffic and status lines.
    always @(posedge core_clk) begin
        if (opcodeStart === 1'b1) opQ.push_back(opcodeWord);
        if (operandStart === 1'b1) wordQ.push_back(operandWord);
        if (operandStart === 1'b1) idxQ.push_back(operandIndex);
        if (storeAck === 1'b1) ackCnt++;
        if (operandRequest === 1'b1) reqSeen = 1'b1;
        if (busyN === 1'b0) busySeen = 1'b1;
    end
    // Next shift register value.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Operand words per category.
    function automatic int words(input logic [3:0] c);
        case (c)
            4'h1, 4'h3, 4'h5, 4'h9, 4'hd: return 1;
            4'h2, 4'h4, 4'ha: return 2;
            4'h6, 4'hb: return 3;
            4'h7: return 7;
            4'h8, 4'hc: return 27;
            default: return 0;
        endcase
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Coprocessor mode: wait for request or for busy to clear.
    task automatic waitfor(input logic onReq);
        int t;
        t = 0;
        while (!mappedMode && (onReq ? operandRequest : busyN) !== 1'b1 && t < 300) begin
            @(posedge core_clk);
            t++;
        end
        if (t == 300) check("pacing wait", 0, 1);
    endtask
    // Opcode, operands, then the engine-side checks.
    task automatic run_instr(input logic [3:0] c);
        logic [DATA_W-1:0] w, r, expW[$];
        logic rd;
        int n, k, t;
        rd = c >= 4'h9 && c <= 4'hd;
        if (c != 4'h1 && c != 4'h2 && c != 4'he) waitfor(1'b0);
        reqSeen = 1'b0;
        busySeen = 1'b0;
        ackCnt = 0;
        seed = lfsr(seed);
        w = {seed[31:20], c, seed[15:0]};
        host_bus_model_inst.lag = seed[1:0];
        host_bus_model_inst.xfer(1'b1, 1'b1, w, 300, r, n);
        for (k = 0; k < words(c); k++) begin
            waitfor(c >= 4'h5 && c <= 4'hc);
            seed = lfsr(seed);
            storeWord <= seed;
            expW.push_back(seed);
            host_bus_model_inst.xfer(1'b0, !rd, seed, 300, r, n);
            if (rd) check("read data", seed, r);
        end
        lastN = n;
        t = 0;
        while ((opQ.size() == 0 || busyN !== 1'b1) && t < 300) begin
            @(posedge core_clk);
            t++;
        end
        check("opcode", w, opQ.size() > 0 ? opQ.pop_front() : ~w);
        if (rd) check("store acks", words(c), ackCnt);
        else check("operand count", words(c), wordQ.size());
        for (k = 0; !rd && k < words(c) && k < wordQ.size(); k++) begin
            check("operand word", expW[k], wordQ[k]);
            check("operand index", k, idxQ[k]);
        end
        if (c == 4'hd) check("busy on status store", 0, busySeen);
        if (c < 4'h5 || c > 4'hc) check("request seen", 0, reqSeen);
        wordQ.delete();
        idxQ.delete();
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog cuts a hang short.
    initial begin
        repeat (90000) @(posedge core_clk);
        fail_count++;
        print_verdict();
    end
    // Scenarios.
    initial begin
        logic [DATA_W-1:0] r;
        int n;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        check("signature", 4'b1100, {busyN, cycleDoneOutN, operandRequest, errorN});
        for (int m = 0; m < 2; m++) begin
            mappedMode <= m[0];
            for (int i = 0; i < 15; i++) run_instr(i[3:0]);
        end
        check("error after signature", 1, errorN);
        errorSummaryBit <= 1'b1;
        run_instr(4'h0);
        check("error raised", 0, errorN);
        errorSummaryBit <= 1'b0;
        run_instr(4'h0);
        check("error cleared", 1, errorN);
        storeReady <= 1'b0;
        fork
            begin
                repeat (40) @(posedge core_clk);
                storeReady <= 1'b1;
            end
            run_instr(4'h9);
        join
        check("read withheld", 1, lastN >= 25);
        mappedMode <= 1'b0;
        for (int j = 0; j < 3; j++) begin
            selectHigh <= j != 0;
            selectLowN <= j == 1;
            chipEnableIn <= j != 2;
            host_bus_model_inst.xfer(1'b1, 1'b1, 32'h00000000, 20, r, n);
            check("refused cycle", 20, n);
        end
        check("outputs released", 1, statusOeN);
        check("no opcode", 0, opQ.size());
        chipEnableIn <= 1'b1;
        selectLowN <= 1'b0;
        selectHigh <= 1'b1;
        hardResetIn <= 1'b1;
        repeat (3) @(posedge core_clk);
        hardResetIn <= 1'b0;
        @(posedge core_clk);
        check("signature again", 4'b1100, {busyN, cycleDoneOutN, operandRequest, errorN});
        run_instr(4'h3);
        print_verdict();
    end
endmodule // coprocessor_host_bus_interface_tb
`default_nettype wire
